//--- logic/tocpwm_cfg.svh
/*
 Register offsets, field positions, reset values and widths for the
 two-channel compare and pwm timer.
 Assumes it is included by the package and the design modules.
*/
`ifndef TOCPWM_CFG_SVH
`define TOCPWM_CFG_SVH

// byte offsets of the register words
`define TOCPWM_TSC_OFS 8'h00
`define TOCPWM_CNT_OFS 8'h04
`define TOCPWM_MOD_OFS 8'h08
`define TOCPWM_CH0SC_OFS 8'h0C
`define TOCPWM_CH0V_OFS 8'h10
`define TOCPWM_CH1SC_OFS 8'h14
`define TOCPWM_CH1V_OFS 8'h18

// timer status/control field positions
`define TOCPWM_TSC_OVF_BIT 7
`define TOCPWM_TSC_OIE_BIT 6
`define TOCPWM_TSC_HALT_BIT 5
`define TOCPWM_TSC_CLR_BIT 4
`define TOCPWM_TSC_DIV_LSB 0

// channel status/control: flag bit position
`define TOCPWM_CH_FLAG_BIT 7

// reset values and the external clock divider code
`define TOCPWM_MOD_RST 16'hFFFF
`define TOCPWM_CNT_RST 16'h0000
`define TOCPWM_VAL_RST 16'h0000
`define TOCPWM_DIV_RST 3'h0
`define TOCPWM_DIV_EXT 3'h7

`endif

//--- logic/tocpwm_pkg.sv
/*
 Types shared by the compare and pwm timer modules.
 Assumes tocpwm_cfg.svh is reachable on the include path.
*/
`include "tocpwm_cfg.svh"

package tocpwm_pkg;
   // one channel status/control byte, msb first
   typedef struct packed {
      logic channel_event_flag;
      logic channel_irq_enable;
      logic ch0_buffer_link_bit;
      logic mode_low_bit;
      logic [1:0] edge_level_select;
      logic toggle_on_overflow;
      logic max_duty_bit;
   } tocpwm_chan_ctrl_type;

   // apb request as seen by the register file
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } tocpwm_apb_req_type;
endpackage

//--- logic/tocpwm_prescaler.sv
/*
 Counter clock prescaler: one-cycle tick at bus clock divided by
 1..64, or on each rising edge of the external timer clock pin.
 Assumes ext_clk is already synchronous to pclk.
*/
`timescale 1ns/1ps
`include "tocpwm_cfg.svh"

module tocpwm_prescaler (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clear,
   input wire logic run,
   input wire logic [2:0] sel,
   input wire logic ext_clk,
   output logic tick
);
   import tocpwm_pkg::*;

   logic [5:0] div_reg;
   logic ext_prev_reg;
   logic [5:0] mask;
   logic ext_rise;

   // divider stage free-runs while counting, cleared with the counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= 6'h00;
      end else if (clear) begin
         div_reg <= 6'h00;
      end else if (run) begin
         div_reg <= div_reg + 6'h01;
      end
   end

   // previous level of the external clock for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= ext_clk;
      end
   end

   // tick selection by divider code
   assign mask = ~(6'h3F << sel);
   assign ext_rise = ext_clk & ~ext_prev_reg;
   always_comb begin
      if (!run || clear) begin
         tick = 1'b0;
      end else if (sel == `TOCPWM_DIV_EXT) begin
         tick = ext_rise;
      end else begin
         tick = ((div_reg & mask) == mask);
      end
   end
endmodule

//--- logic/tocpwm_top.sv
/*
 Two-channel 16-bit modulo timer: output compare, pwm by toggle on
 overflow, buffered pairing of channels 0 and 1, flags and requests.
 Assumes an apb master on pclk and pins synchronous to pclk.
*/
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tocpwm_cfg.svh"

module tocpwm_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic wait_mode,
   input wire logic ext_timer_clk,
   input wire logic channel0_pin_in,
   output logic channel0_pin_out,
   output logic channel0_pin_oe,
   input wire logic channel1_pin_in,
   output logic channel1_pin_out,
   output logic channel1_pin_oe,
   output logic overflow_irq,
   output logic [1:0] channel_irq,
   output logic wake_req
);
   import tocpwm_pkg::*;

   tocpwm_apb_req_type req;
   logic [15:0] counter_reg;
   logic [15:0] counter_modulo_value_reg;
   logic overflow_flag_reg;
   logic overflow_irq_enable_reg;
   logic counter_halt_reg;
   logic [2:0] clock_divider_select_reg;
   logic ovf_arm_reg;
   tocpwm_chan_ctrl_type chan_ctrl_reg [2];
   logic [15:0] chan_value_reg [2];
   logic [1:0] chan_arm_reg;
   logic [1:0] pin_reg;
   logic [1:0] oe_reg;
   logic active_sel_reg;
   logic last_written_reg;
   logic link_prev_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic overflow_irq_reg;
   logic [1:0] channel_irq_reg;
   logic wake_req_reg;

   logic tick;
   logic clear_pulse;
   logic wr_done;
   logic rd_done;
   logic rollover;
   logic [15:0] counter_next;
   logic link;
   logic [1:0] cmp_event;
   logic [1:0] val_wr;
   logic [31:0] rd_mux;
   logic rd_hit;

   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign link = chan_ctrl_reg[0].ch0_buffer_link_bit;

   // completed transfers; refused accesses in wait mode have no effect
   assign wr_done = req.sel & req.enable & pready_reg & req.write & ~pslverr_reg;
   assign rd_done = req.sel & req.enable & pready_reg & ~req.write & ~pslverr_reg;
   assign clear_pulse = wr_done & (req.addr == `TOCPWM_TSC_OFS)
      & req.wdata[`TOCPWM_TSC_CLR_BIT];
   assign val_wr[0] = wr_done & (req.addr == `TOCPWM_CH0V_OFS);
   assign val_wr[1] = wr_done & (req.addr == `TOCPWM_CH1V_OFS);

   tocpwm_prescaler u_prescaler (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear_pulse),
      .run(~counter_halt_reg),
      .sel(clock_divider_select_reg),
      .ext_clk(ext_timer_clk),
      .tick(tick)
   );

   // next count and rollover at the modulo value
   assign rollover = tick & (counter_reg == counter_modulo_value_reg);
   assign counter_next = rollover ? 16'h0000 : counter_reg + 16'h0001;

   // counter keeps running in wait mode; only halt or clear stop it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_reg <= `TOCPWM_CNT_RST;
      end else if (clear_pulse) begin
         counter_reg <= 16'h0000;
      end else if (tick) begin
         counter_reg <= counter_next;
      end
   end

   // timer status/control fields
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq_enable_reg <= 1'b0;
         counter_halt_reg <= 1'b1;
         clock_divider_select_reg <= `TOCPWM_DIV_RST;
      end else if (wr_done && req.addr == `TOCPWM_TSC_OFS) begin
         overflow_irq_enable_reg <= req.wdata[`TOCPWM_TSC_OIE_BIT];
         counter_halt_reg <= req.wdata[`TOCPWM_TSC_HALT_BIT];
         clock_divider_select_reg <= req.wdata[`TOCPWM_TSC_DIV_LSB +: 3];
      end
   end

   // overflow flag: rollover sets, armed zero write clears, set wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag_reg <= 1'b0;
         ovf_arm_reg <= 1'b0;
      end else if (rollover) begin
         overflow_flag_reg <= 1'b1;
         ovf_arm_reg <= 1'b0;
      end else if (wr_done && req.addr == `TOCPWM_TSC_OFS) begin
         if (ovf_arm_reg && !req.wdata[`TOCPWM_TSC_OVF_BIT]) begin
            overflow_flag_reg <= 1'b0;
         end
         ovf_arm_reg <= 1'b0;
      end else if (rd_done && req.addr == `TOCPWM_TSC_OFS) begin
         ovf_arm_reg <= prdata_reg[`TOCPWM_TSC_OVF_BIT];
      end
   end

   // modulo register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         counter_modulo_value_reg <= `TOCPWM_MOD_RST;
      end else if (wr_done && req.addr == `TOCPWM_MOD_OFS) begin
         counter_modulo_value_reg <= req.wdata[15:0];
      end
   end

   // buffered pairing: channel 0 leads, last written pair takes over
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_sel_reg <= 1'b0;
         last_written_reg <= 1'b0;
         link_prev_reg <= 1'b0;
      end else begin
         link_prev_reg <= link;
         if (link && !link_prev_reg) begin
            active_sel_reg <= 1'b0;
            last_written_reg <= 1'b0;
         end else begin
            if (val_wr != 2'b00) begin
               last_written_reg <= val_wr[1];
            end
            if (rollover) begin
               active_sel_reg <= last_written_reg;
            end
         end
      end
   end

   // per-channel compare, pin action, flag and registers
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
         logic [15:0] cmp_value;
         logic out_mode;
         logic [7:0] sc_addr;
         logic [7:0] val_addr;
         logic cmp_force;
         assign sc_addr = (gi == 0) ? `TOCPWM_CH0SC_OFS : `TOCPWM_CH1SC_OFS;
         assign val_addr = (gi == 0) ? `TOCPWM_CH0V_OFS : `TOCPWM_CH1V_OFS;
         // channel 1 is silent while paired; channel 0 follows active pair
         if (gi == 0) begin : g_c0
            assign cmp_value = (link && active_sel_reg) ? chan_value_reg[1]
               : chan_value_reg[0];
            assign out_mode = link | chan_ctrl_reg[0].mode_low_bit;
         end else begin : g_c1
            assign cmp_value = chan_value_reg[1];
            assign out_mode = ~link & chan_ctrl_reg[1].mode_low_bit;
         end
         // equality on the next count only, so a passed value waits
         assign cmp_event[gi] = tick & out_mode & (counter_next == cmp_value);
         assign cmp_force = cmp_event[gi] & (chan_ctrl_reg[gi].edge_level_select != 2'b00);

         // compare value writes replace the live value at once
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan_value_reg[gi] <= `TOCPWM_VAL_RST;
            end else if (wr_done && req.addr == val_addr) begin
               chan_value_reg[gi] <= req.wdata[15:0];
            end
         end

         // control bits (no link bit on channel 1) and flag; event beats clear
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chan_ctrl_reg[gi] <= '0;
               chan_arm_reg[gi] <= 1'b0;
            end else begin
               if (wr_done && req.addr == sc_addr) begin
                  chan_ctrl_reg[gi][6:0] <= {req.wdata[6], (gi == 0) && req.wdata[5],
                     req.wdata[4:0]};
                  chan_arm_reg[gi] <= 1'b0;
                  if (chan_arm_reg[gi] && !req.wdata[`TOCPWM_CH_FLAG_BIT]) begin
                     chan_ctrl_reg[gi].channel_event_flag <= 1'b0;
                  end
               end else if (rd_done && req.addr == sc_addr) begin
                  chan_arm_reg[gi] <= prdata_reg[`TOCPWM_CH_FLAG_BIT];
               end
               if (cmp_event[gi]) begin
                  chan_ctrl_reg[gi].channel_event_flag <= 1'b1;
                  chan_arm_reg[gi] <= 1'b0;
               end
            end
         end

         // pin: overflow toggle first, then compare action overrides
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_reg[gi] <= 1'b0;
               oe_reg[gi] <= 1'b0;
            end else begin
               oe_reg[gi] <= out_mode & (chan_ctrl_reg[gi].edge_level_select != 2'b00);
               if (chan_ctrl_reg[gi].max_duty_bit
                  && !chan_ctrl_reg[gi].toggle_on_overflow) begin
                  pin_reg[gi] <= 1'b1;
               end else if (cmp_force) begin
                  case (chan_ctrl_reg[gi].edge_level_select)
                     2'b01: pin_reg[gi] <= ~pin_reg[gi];
                     2'b10: pin_reg[gi] <= 1'b0;
                     2'b11: pin_reg[gi] <= 1'b1;
                     default: pin_reg[gi] <= pin_reg[gi];
                  endcase
               end else if (rollover && out_mode
                  && chan_ctrl_reg[gi].toggle_on_overflow) begin
                  pin_reg[gi] <= ~pin_reg[gi];
               end
            end
         end
      end
   endgenerate

   // read mux over the register words
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (req.addr)
         `TOCPWM_TSC_OFS: begin
            rd_mux[`TOCPWM_TSC_OVF_BIT] = overflow_flag_reg;
            rd_mux[`TOCPWM_TSC_OIE_BIT] = overflow_irq_enable_reg;
            rd_mux[`TOCPWM_TSC_HALT_BIT] = counter_halt_reg;
            rd_mux[`TOCPWM_TSC_DIV_LSB +: 3] = clock_divider_select_reg;
         end
         `TOCPWM_CNT_OFS: rd_mux[15:0] = counter_reg;
         `TOCPWM_MOD_OFS: rd_mux[15:0] = counter_modulo_value_reg;
         `TOCPWM_CH0SC_OFS: rd_mux[7:0] = chan_ctrl_reg[0];
         `TOCPWM_CH0V_OFS: rd_mux[15:0] = chan_value_reg[0];
         `TOCPWM_CH1SC_OFS: rd_mux[7:0] = chan_ctrl_reg[1];
         `TOCPWM_CH1V_OFS: rd_mux[15:0] = chan_value_reg[1];
         default: rd_hit = 1'b0;
      endcase
   end

   // apb slave: answer prepared in setup, ready for one access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= req.sel & ~req.enable;
         pslverr_reg <= req.sel & ~req.enable & (~rd_hit | wait_mode);
         if (req.sel && !req.enable) begin
            prdata_reg <= (rd_hit && !wait_mode) ? rd_mux : 32'h0000_0000;
         end
      end
   end

   // requests: each flag gated by its enable; any one wakes in wait mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_irq_reg <= 1'b0;
         channel_irq_reg <= 2'b00;
         wake_req_reg <= 1'b0;
      end else begin
         overflow_irq_reg <= overflow_flag_reg & overflow_irq_enable_reg;
         channel_irq_reg[0] <= chan_ctrl_reg[0].channel_event_flag
            & chan_ctrl_reg[0].channel_irq_enable;
         channel_irq_reg[1] <= chan_ctrl_reg[1].channel_event_flag
            & chan_ctrl_reg[1].channel_irq_enable & ~link;
         wake_req_reg <= wait_mode & ((overflow_flag_reg & overflow_irq_enable_reg)
            | (chan_ctrl_reg[0].channel_event_flag & chan_ctrl_reg[0].channel_irq_enable)
            | (chan_ctrl_reg[1].channel_event_flag
            & chan_ctrl_reg[1].channel_irq_enable & ~link));
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign channel0_pin_out = pin_reg[0];
   assign channel0_pin_oe = oe_reg[0];
   assign channel1_pin_out = pin_reg[1];
   assign channel1_pin_oe = oe_reg[1];
   assign overflow_irq = overflow_irq_reg;
   assign channel_irq = channel_irq_reg;
   assign wake_req = wake_req_reg;
endmodule

//--- test/test_timer_output_compare_pwm.sv
/*
 Testbench for tocpwm_top: register access, pwm timing, flags, wait mode.
 Assumes the checker binds itself and the pin loads stand on both pins.
*/
`timescale 1ns/1ps

module test_timer_output_compare_pwm;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic wait_mode = 1'b0;
   logic [2:0] ext_cnt = 3'h0;
   logic [31:0] prdata, rd, saved;
   logic pready, pslverr, er, overflow_irq, wake_req;
   logic ch0_out, ch0_oe, ch0_lvl, ch1_out, ch1_oe, ch1_lvl;
   logic [1:0] channel_irq;
   logic [15:0] p0_period, p0_high, p1_period;
   int bad_count = 0;
   int n_checks = 0;
   int k;

   // 100 MHz bus clock
   always #5 pclk = ~pclk;
   // external counter clock: one rising edge every eight bus clocks
   always_ff @(posedge pclk) ext_cnt <= ext_cnt + 3'h1;

   tocpwm_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wait_mode(wait_mode), .ext_timer_clk(ext_cnt[2]),
      .channel0_pin_in(ch0_lvl), .channel0_pin_out(ch0_out), .channel0_pin_oe(ch0_oe),
      .channel1_pin_in(ch1_lvl), .channel1_pin_out(ch1_out), .channel1_pin_oe(ch1_oe),
      .overflow_irq(overflow_irq), .channel_irq(channel_irq), .wake_req(wake_req));
   tocpwm_pin_load i_load0 (.pclk(pclk), .pin_out(ch0_out), .pin_oe(ch0_oe),
      .level(ch0_lvl), .period(p0_period), .high(p0_high));
   tocpwm_pin_load i_load1 (.pclk(pclk), .pin_out(ch1_out), .pin_oe(ch1_oe),
      .level(ch1_lvl), .period(p1_period), .high());

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one apb transfer: setup, then access until ready
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n == 20) chk(32'h0, 32'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // watchdog against a hang
   initial begin
      #300000;
      bad_count++;
      close_out;
   end

   initial begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // reset values, read-only counter, unmapped place
      rdchk(8'h00, 32'h20);
      rdchk(8'h08, 32'hFFFF);
      xfer(1'b1, 8'h04, 32'h5);
      rdchk(8'h04, 32'h0);
      xfer(1'b0, 8'h40, 32'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      $display("test reset done");
      // 8-bit pwm, overflow flag and its clearing sequence
      xfer(1'b1, 8'h00, 32'h30);
      rdchk(8'h00, 32'h20);
      xfer(1'b1, 8'h08, 32'hFF);
      xfer(1'b1, 8'h10, 32'h80);
      xfer(1'b1, 8'h0C, 32'h1A);
      xfer(1'b1, 8'h00, 32'h0);
      cyc(600);
      chk({16'h0, p0_period}, 32'h100);
      chk({16'h0, p0_high}, 32'h80);
      rdchk(8'h00, 32'h80);
      chk({31'h0, overflow_irq}, 32'h0);
      xfer(1'b1, 8'h00, 32'h40);
      cyc(300);
      chk({31'h0, overflow_irq}, 32'h1);
      xfer(1'b1, 8'h00, 32'h60);
      xfer(1'b0, 8'h04, 32'h0);
      saved = rd;
      cyc(40);
      rdchk(8'h04, saved);
      rdchk(8'h00, 32'hE0);
      xfer(1'b1, 8'h00, 32'h60);
      rdchk(8'h00, 32'h60);
      xfer(1'b1, 8'h00, 32'hE0);
      rdchk(8'h00, 32'h60);
      $display("test pwm done");
      // wait mode: timer runs, bus refused, request wakes
      xfer(1'b1, 8'h00, 32'h40);
      wait_mode <= 1'b1;
      cyc(300);
      chk({31'h0, wake_req}, 32'h1);
      xfer(1'b0, 8'h00, 32'h0);
      chk({31'h0, er}, 32'h1);
      wait_mode <= 1'b0;
      $display("test wait done");
      // every divider code, short period of 16 counts
      xfer(1'b1, 8'h00, 32'h30);
      xfer(1'b1, 8'h08, 32'hF);
      xfer(1'b1, 8'h10, 32'h8);
      for (int c = 0; c < 8; c++) begin
         k = (c == 7) ? 128 : 16 << c;
         xfer(1'b1, 8'h00, 32'(c));
         cyc(3 * k + 40);
         chk({16'h0, p0_period}, 32'(k));
         chk({16'h0, p0_high}, 32'(k / 2));
      end
      $display("test divider done");
      // zero and full duty without toggle on overflow
      xfer(1'b1, 8'h00, 32'h0);
      xfer(1'b1, 8'h0C, 32'h18);
      cyc(50);
      chk({31'h0, ch0_lvl}, 32'h0);
      cyc(9);
      chk({31'h0, ch0_lvl}, 32'h0);
      xfer(1'b1, 8'h0C, 32'h19);
      cyc(50);
      chk({31'h0, ch0_lvl}, 32'h1);
      cyc(9);
      chk({31'h0, ch0_lvl}, 32'h1);
      $display("test duty done");
      // channel 1 toggle on compare, its flag and request
      xfer(1'b1, 8'h18, 32'h3);
      xfer(1'b1, 8'h14, 32'h54);
      cyc(100);
      chk({16'h0, p1_period}, 32'h20);
      rdchk(8'h14, 32'hD4);
      chk({30'h0, channel_irq}, 32'h2);
      xfer(1'b1, 8'h00, 32'h20);
      rdchk(8'h14, 32'hD4);
      xfer(1'b1, 8'h14, 32'h54);
      rdchk(8'h14, 32'h54);
      $display("test compare done");
      // linked pair: channel 0 first, then last written at overflow
      xfer(1'b1, 8'h00, 32'h30);
      xfer(1'b1, 8'h18, 32'hC);
      xfer(1'b1, 8'h10, 32'h4);
      xfer(1'b1, 8'h0C, 32'h3A);
      xfer(1'b1, 8'h00, 32'h0);
      cyc(60);
      chk({16'h0, p0_high}, 32'h4);
      chk({31'h0, ch1_oe}, 32'h0);
      xfer(1'b1, 8'h18, 32'hC);
      cyc(60);
      chk({16'h0, p0_high}, 32'hC);
      xfer(1'b1, 8'h10, 32'h2);
      cyc(60);
      chk({16'h0, p0_high}, 32'h2);
      $display("test buffered done");
      close_out;
   end
endmodule

//--- test/tocpwm_pin_load.sv
/*
 Load on one timer channel pin: pull-down resistor and a pulse meter.
 Assumes the pin outputs are synchronous to pclk.
*/
`timescale 1ns/1ps

module tocpwm_pin_load (
   input wire logic pclk,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic level,
   output logic [15:0] period,
   output logic [15:0] high
);
   logic prev = 1'b0;
   logic [15:0] run_cnt = 16'h0;
   logic [15:0] high_cnt = 16'h0;

   // released pin is pulled low
   assign level = pin_oe ? pin_out : 1'b0;

   // cycles between rising edges and width of each high pulse
   always_ff @(posedge pclk) begin
      prev <= level;
      run_cnt <= (level && !prev) ? 16'h1 : run_cnt + 16'h1;
      high_cnt <= level ? (prev ? high_cnt + 16'h1 : 16'h1) : 16'h0;
      if (level && !prev) period <= run_cnt;
      if (!level && prev) high <= high_cnt;
   end
endmodule

//--- test/tocpwm_properties.sv
/*
 Port checks for tocpwm_top: bus answer timing, refusals, wake request.
 Assumes one clock, pclk, and presetn as the asynchronous reset.
*/
`timescale 1ns/1ps

module tocpwm_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic wait_mode,
   input wire logic overflow_irq,
   input wire logic [1:0] channel_irq,
   input wire logic wake_req
);
   logic setup;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // setup phase of a bus transfer
   assign setup = psel && !penable;

   // bus answer timing and refusals
   a_ready_after_setup: assert property (setup |=> pready)
      else $error("ready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held too long");
   a_idle_no_ready: assert property (!psel |=> !pready)
      else $error("ready without request");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("error outside access");
   a_err_zero_data: assert property (pready && pslverr |-> prdata == 32'h0)
      else $error("refused read returns data");
   a_unmapped_err: assert property (setup && !wait_mode && paddr > 8'h18 |=> pslverr)
      else $error("unmapped access accepted");
   a_mapped_ok: assert property (setup && !wait_mode && paddr <= 8'h18
      && paddr[1:0] == 2'h0 |=> !pslverr)
      else $error("mapped access refused");
   a_wait_refused: assert property (setup && wait_mode |=> pslverr)
      else $error("access accepted in wait mode");
   // wake request follows enabled requests in wait mode only
   a_wake_cause: assert property ($past(wait_mode)
      && (overflow_irq || channel_irq != 2'h0) |-> wake_req)
      else $error("enabled request did not wake");
   a_wake_source: assert property (wake_req |-> $past(wait_mode))
      else $error("wake outside wait mode");
endmodule

bind tocpwm_top tocpwm_properties i_props (
   .pclk(pclk),
   .presetn(presetn),
   .psel(psel),
   .penable(penable),
   .paddr(paddr),
   .prdata(prdata),
   .pready(pready),
   .pslverr(pslverr),
   .wait_mode(wait_mode),
   .overflow_irq(overflow_irq),
   .channel_irq(channel_irq),
   .wake_req(wake_req)
);
